// [dv/tsc_host_model.sv]
// Purpose: bus controller that talks to the sensor target
// Assumes: lines are open drain with pull-ups, resolved outside
// Notes: ok drops if a stretched clock never comes back
`timescale 1ns/100ps
module tsc_host_model (
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	logic ok = 1'b1;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge link_clk_i);
	endtask
	// release scl, then wait while the target stretches it
	task automatic rise;
		int i;
		scl_o <= 1'b1;
		w(1);
		for (i = 0; i < 4000 && scl_i !== 1'b1; i++) w(1);
		if (i == 4000) ok = 1'b0;
		w(8);
	endtask
	task automatic start;
		sda_o <= 1'b1;
		w(4);
		// clock out a target that still holds sda low
		for (int k = 0; k < 9 && sda_i !== 1'b1; k++) begin
			scl_o <= 1'b0;
			w(8);
			rise();
		end
		rise();
		sda_o <= 1'b0;
		w(8);
		scl_o <= 1'b0;
		w(8);
	endtask
	task automatic stop;
		sda_o <= 1'b0;
		w(4);
		rise();
		sda_o <= 1'b1;
		w(8);
	endtask
	task automatic bt(input logic b, output logic r);
		sda_o <= b;
		w(8);
		rise();
		r = sda_i;
		scl_o <= 1'b0;
		w(8);
	endtask
	task automatic xb(input logic [7:0] d, input logic ai,
		output logic [7:0] q, output logic ao);
		for (int k = 7; k >= 0; k--) bt(d[k], q[k]);
		bt(ai, ao);
	endtask
endmodule

// [dv/tsc_target_bench.sv]
// Purpose: self-checking bench of the sensor command target
// Assumes: short conversion through the CONV_CYCLES parameter
// Notes: host model clocks the bus from the link clock
`timescale 1ns/100ps
module tsc_target_bench;
	import tsc_pkg::*;
	localparam int CONV = 8000;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic rst, h_scl, h_sda, scl_o, scl_oe, sda_o, sda_oe, busy;
	logic [15:0] raw;
	wire logic scl = h_scl & ~(scl_oe & ~scl_o);
	wire logic sda = h_sda & ~(sda_oe & ~sda_o);
	int n_mismatch = 0;
	int samples_checked = 0;
	always #12.5 clk = ~clk;
	initial begin
		#31;
		forever #62.5 lclk = ~lclk;
	end
	tsc_target #(.CONV_CYCLES(CONV)) tsc_target_inst (.clk_i(clk),
		.rst_i(rst), .link_clk_i(lclk), .scl_i(scl), .scl_o(scl_o),
		.scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.raw_temp_code_i(raw), .conv_busy_o(busy));
	tsc_host_model host (.link_clk_i(lclk), .scl_i(scl), .sda_i(sda),
		.scl_o(h_scl), .sda_o(h_sda));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// a stretched clock that never comes back ends the run
	always @(negedge host.ok) begin
		n_mismatch++;
		stop_test();
	end
	task automatic chk(input string nm, input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [7:0] crc_ref(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			c = (c << 1) ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
		end
		return c;
	endfunction
	// controller side scaling, degrees times 100
	function automatic logic [15:0] centi_deg(input logic [15:0] code);
		real t;
		t = code / 65536.0 * 175.72 - 46.85;
		return 16'($rtoi(t * 100.0 + 0.5));
	endfunction
	task automatic wr(input logic [7:0] c, input bit fin);
		logic [7:0] q;
		logic a;
		host.start();
		host.xb({DEV_ADDR, 1'b0}, 1'b1, q, a);
		chk("write addr ack", a, 1'b0);
		host.xb(c, 1'b1, q, a);
		chk("cmd ack", a, 1'b0);
		if (fin) host.stop();
	endtask
	// read n bytes, refuse the last, then clock one more byte when n is below 3
	task automatic rd(input logic nak, input logic [15:0] v, input int n);
		logic [7:0] q;
		logic a;
		logic [23:0] e;
		logic [23:0] g;
		e = {v, crc_ref({8'h00, v})};
		g = 24'h000000;
		host.start();
		host.xb({DEV_ADDR, 1'b1}, 1'b1, q, a);
		chk("read addr ack", a, nak);
		for (int i = 0; i < n && !nak; i++) begin
			host.xb(8'hff, i == n - 1, q, a);
			g[23 - 8 * i -: 8] = q;
			chk("read byte", q, e[23 - 8 * i -: 8]);
		end
		if (!nak && n == 3) begin
			chk("remainder", crc_ref(g), 8'h00);
		end
		if (!nak && n < 3) begin
			host.xb(8'hff, 1'b1, q, a);
			chk("after refusal", q, 8'hff);
		end
		host.stop();
	endtask
	task automatic wait_idle;
		int i;
		for (i = 0; i < 10000 && busy !== 1'b0; i++) @(posedge clk);
		if (i == 10000) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	task automatic t_idle;
		logic [7:0] q;
		logic a;
		rd(1'b0, 16'h0000, 3);
		host.start();
		host.xb(8'h82, 1'b1, q, a);
		chk("foreign addr", a, 1'b1);
		host.stop();
	endtask
	task automatic t_hold;
		chk("crc example", crc_ref(24'h00683a), 8'h7c);
		chk("celsius", centi_deg(16'h683a), 16'h09a5);
		@(posedge clk) raw <= 16'h683a;
		wr(CMD_CONV_HOLD, 1'b0);
		host.w(24);
		#1;
		chk("scl held", scl_oe, 1'b1);
		chk("busy", busy, 1'b1);
		rd(1'b0, 16'h683a, 3);
	endtask
	task automatic t_free;
		@(posedge clk) raw <= 16'h8001;
		wr(CMD_CONV_FREE, 1'b1);
		rd(1'b1, 16'h0000, 0);
		wr(CMD_CONV_HOLD, 1'b1);
		#1;
		chk("scl free", scl_oe, 1'b0);
		wait_idle();
		rd(1'b0, 16'h8001, 1);
	endtask
	task automatic t_reset;
		@(posedge clk) raw <= 16'h1234;
		wr(CMD_CONV_FREE, 1'b1);
		wr(CMD_RESET, 1'b1);
		repeat (4) @(posedge clk);
		#1;
		chk("busy after reset", busy, 1'b0);
		rd(1'b0, 16'h0000, 2);
	endtask
	initial begin
		rst = 1'b1;
		raw = 16'h0000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		t_idle();
		t_hold();
		t_free();
		t_reset();
		chk("bus alive", host.ok, 1'b1);
		stop_test();
	end
endmodule

// [dv/tsc_target_monitor.sv]
// Purpose: bus and conversion checks on the sensor target
// Assumes: bound to tsc_target, conversion length as a parameter
// Notes: two clock domains, each property names its own clock
`timescale 1ns/100ps
module tsc_target_monitor #(
	parameter int unsigned CONV_CYCLES = 2000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [15:0] raw_temp_code_i,
	input wire logic conv_busy_o
);
	int unsigned busy_n, idle_n, hold_n;
	always_ff @(posedge clk_i) begin
		busy_n <= (rst_i || !conv_busy_o) ? 0 : busy_n + 1;
		if (rst_i || conv_busy_o) begin
			idle_n <= 0;
		end else if (idle_n < 100) begin
			idle_n <= idle_n + 1;
		end
	end
	always_ff @(posedge link_clk_i) begin
		hold_n <= scl_oe_o ? hold_n + 1 : 0;
	end
	// link side leaves reset a few link clocks after the core
	logic [2:0] lwarm;
	wire lrdy = lwarm == 3'h7;
	always_ff @(posedge link_clk_i) begin
		if (rst_i) begin
			lwarm <= 3'h0;
		end else if (!lrdy) begin
			lwarm <= lwarm + 3'h1;
		end
	end
	drain_low_a: assert property (@(posedge link_clk_i)
		disable iff (rst_i || !lrdy) !scl_o && !sda_o)
		else $error("pin driven high");
	rst_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> !conv_busy_o)
		else $error("busy set after reset");
	link_clear_a: assert property (@(posedge link_clk_i)
		disable iff (rst_i) lwarm == 3'h3 |-> !scl_oe_o && !sda_oe_o)
		else $error("pins driven after reset");
	busy_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(conv_busy_o) |-> conv_busy_o [*8]) else $error("busy too short");
	busy_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
		busy_n < CONV_CYCLES + 8) else $error("busy too long");
	hold_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		idle_n == 100 |-> !scl_oe_o) else $error("scl held while idle");
	hold_bound_a: assert property (@(posedge link_clk_i)
		disable iff (rst_i || !lrdy) hold_n < CONV_CYCLES / 5 + 32)
		else $error("scl held too long");
	stretch_low_a: assert property (@(posedge link_clk_i)
		disable iff (rst_i || !lrdy) $rose(scl_oe_o) |-> !scl_i)
		else $error("stretch began with scl high");
	sda_change_a: assert property (@(posedge link_clk_i)
		disable iff (rst_i || !lrdy) $changed(sda_oe_o) |-> !scl_i)
		else $error("sda moved while scl high");
	cover property (@(posedge link_clk_i) $rose(scl_oe_o));
	cover property (@(posedge clk_i) $fell(conv_busy_o));
	cover property (@(posedge link_clk_i) $rose(sda_oe_o));
endmodule
bind tsc_target tsc_target_monitor #(.CONV_CYCLES(CONV_CYCLES)) mon_inst (
	.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
	.scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .raw_temp_code_i(raw_temp_code_i),
	.conv_busy_o(conv_busy_o));

// [src/tsc_crc8.sv]
// Purpose: check byte over a 16-bit word, msb first
// Assumes: purely combinational
// Notes: one divider stage per data bit

`timescale 1ns/100ps

module tsc_crc8 (
	input wire logic [15:0] data_i,
	output logic [7:0] crc_o
);
	import tsc_pkg::*;

	logic [7:0] stage [0:16];

	assign stage[0] = CRC_INIT; // RULE_13
	for (genvar i = 0; i < 16; i++) begin : g_div
		// divisor is applied when the leading bit is one
		assign stage[i + 1] = {stage[i][6:0], 1'b0} ^
			((stage[i][7] ^ data_i[15 - i]) ? CRC_POLY : 8'h00); // RULE_14
	end
	assign crc_o = stage[16]; // RULE_12
endmodule

// [src/tsc_pkg.sv]
// Purpose: shared constants and types of the sensor command target
// Assumes: core clock at 40 MHz, link sampling clock free running
// Notes: all widths are fixed

package tsc_pkg;

	// ************************************************************
	// link protocol
	// ************************************************************
	localparam logic [6:0] DEV_ADDR = 7'h40;
	localparam logic [7:0] CMD_RESET = 8'hfe;
	localparam logic [7:0] CMD_CONV_HOLD = 8'he3;
	localparam logic [7:0] CMD_CONV_FREE = 8'hf3;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [1:0] FIRST_BYTE = 2'h1;
	localparam logic [1:0] ALL_BYTES = 2'h3;

	// ************************************************************
	// check byte
	// ************************************************************
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// ************************************************************
	// timing and reset values
	// ************************************************************
	localparam int CLK_HZ = 40000000;
	localparam int CONV_TIME_US = 43000;
	localparam int CONV_CYCLES = CONV_TIME_US * (CLK_HZ / 1000000);
	localparam int TIMER_W = 24;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [7:0] CRC_RST = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_CMD = 3'b011,
		ST_CMD_ACK = 3'b100,
		ST_HOLD = 3'b101,
		ST_TX = 3'b110,
		ST_TX_ACK = 3'b111
	} tsc_link_st_t;

endpackage

// [src/tsc_target.sv]
// Purpose: serial command target of a temperature sensor
// Assumes: link_clk_i oversamples the bus, runs free
// Notes: scl and sda are open drain, driven low only
//
// Overview of operation
// RULE_01 - frames open on start, close on stop
// RULE_02 - controller sends address then one command
// RULE_03 - answer only address 1000000, last bit direction
// RULE_04 - command fe resets, even while converting
// RULE_05 - command e3 converts, holds scl until done
// RULE_06 - command f3 converts, scl left free
// RULE_07 - busy: ignore all commands except reset
// RULE_08 - controller clocks 24 bits of result
// RULE_09 - controller acknowledges after each result byte
// RULE_10 - missing acknowledge stops the result shifting
// RULE_11 - controller recovers stuck sda by clocking
// RULE_12 - check byte uses x8+x5+x4+1
// RULE_13 - check covers read data, start zero
// RULE_14 - msb first division, zero padded remainder
// RULE_15 - controller checks zero remainder on receipt
// RULE_16 - controller scales raw code to celsius
// RULE_17 - send high byte, low byte, check

`timescale 1ns/100ps

module tsc_target #(
	parameter int unsigned CONV_CYCLES = tsc_pkg::CONV_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [15:0] raw_temp_code_i,
	output logic conv_busy_o
);
	import tsc_pkg::*;

	// ************************************************************
	// core domain declarations
	// ************************************************************
	logic conv_m, conv_s, conv_p;
	logic cmdrst_m, cmdrst_s, cmdrst_p;
	logic [TIMER_W-1:0] timer;
	logic [15:0] raw_temp_code;
	logic [7:0] crc;
	logic [7:0] crc_calc;
	wire conv_ev = conv_s ^ conv_p;
	wire cmdrst_ev = cmdrst_s ^ cmdrst_p;
	wire conv_end = timer == TIMER_W'(CONV_CYCLES - 1);

	// ************************************************************
	// link domain declarations
	// ************************************************************
	logic lrst_m, lrst;
	logic scl_m, scl_s, scl_p;
	logic sda_m, sda_s, sda_p;
	logic busy_m, busy_s;
	tsc_link_st_t st;
	logic [7:0] sh;
	logic [3:0] cnt;
	logic rw, hold_req, mack, conv_pend;
	logic [1:0] byte_idx;
	logic conv_tgl, cmdrst_tgl;
	logic pull_low;
	logic [7:0] tx_byte;

	wire start_c = scl_s & scl_p & sda_p & ~sda_s; // RULE_01
	wire stop_c = scl_s & scl_p & ~sda_p & sda_s; // RULE_01
	wire rise = scl_s & ~scl_p;
	wire fall = ~scl_s & scl_p;
	wire busy_link = busy_s | conv_pend;
	wire byte_done = fall & (cnt == BITS_PER_BYTE);
	wire addr_hit = sh[7:1] == DEV_ADDR; // RULE_03
	wire addr_ack = addr_hit & ~(sh[0] & busy_link);
	wire is_conv = (sh == CMD_CONV_HOLD) | (sh == CMD_CONV_FREE);
	wire conv_ok = is_conv & ~busy_link; // RULE_07
	wire more = mack & (byte_idx != ALL_BYTES); // RULE_10

	// the result words only change as busy falls, on the reset command or on rst_i,
	// so a read that follows busy low sees them stable
	assign tx_byte = (byte_idx == 2'h0) ? raw_temp_code[15:8] :
		(byte_idx == 2'h1) ? raw_temp_code[7:0] : crc; // RULE_17

	tsc_crc8 u_crc (
		.data_i(raw_temp_code_i),
		.crc_o(crc_calc)
	);

	// ************************************************************
	// core: crossings from the link
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{conv_m, conv_s, conv_p} <= 3'h0;
			{cmdrst_m, cmdrst_s, cmdrst_p} <= 3'h0;
		end else begin
			{conv_m, conv_s, conv_p} <= {conv_tgl, conv_m, conv_s};
			{cmdrst_m, cmdrst_s, cmdrst_p} <= {cmdrst_tgl, cmdrst_m,
				cmdrst_s};
		end
	end

	// ************************************************************
	// core: conversion engine
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_busy_o <= 1'b0;
			timer <= '0;
			raw_temp_code <= RESULT_RST;
			crc <= CRC_RST;
		end else if (cmdrst_ev) begin
			// reset wins over a conversion in flight
			conv_busy_o <= 1'b0; // RULE_04
			timer <= '0;
			raw_temp_code <= RESULT_RST;
			crc <= CRC_RST;
		end else if (conv_ev & ~conv_busy_o) begin
			conv_busy_o <= 1'b1; // RULE_05 RULE_06
			timer <= '0;
		end else if (conv_busy_o) begin
			if (conv_end) begin
				conv_busy_o <= 1'b0;
				raw_temp_code <= raw_temp_code_i;
				crc <= crc_calc; // RULE_13
			end else begin
				timer <= timer + 1'b1;
			end
		end
	end

	// ************************************************************
	// link: reset and pin synchronisers
	// ************************************************************
	always_ff @(posedge link_clk_i) begin
		lrst_m <= rst_i;
		lrst <= lrst_m;
	end

	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			{scl_m, scl_s, scl_p} <= 3'h7;
			{sda_m, sda_s, sda_p} <= 3'h7;
			{busy_m, busy_s} <= 2'h0;
		end else begin
			{scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
			{sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
			{busy_m, busy_s} <= {conv_busy_o, busy_m};
		end
	end

	// ************************************************************
	// link: protocol engine
	// ************************************************************
	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			st <= ST_IDLE;
			sh <= 8'h00;
			cnt <= 4'h0;
			rw <= 1'b0;
			hold_req <= 1'b0;
			mack <= 1'b0;
			conv_pend <= 1'b0;
			byte_idx <= 2'h0;
			conv_tgl <= 1'b0;
			cmdrst_tgl <= 1'b0;
			pull_low <= 1'b0;
			sda_oe_o <= 1'b0;
			scl_oe_o <= 1'b0;
		end else begin
			if (busy_s) begin
				conv_pend <= 1'b0;
			end
			if (start_c) begin
				st <= ST_ADDR; // RULE_01
				cnt <= 4'h0;
				sda_oe_o <= 1'b0;
			end else if (stop_c) begin
				st <= ST_IDLE; // RULE_01
				sda_oe_o <= 1'b0;
			end else begin
				case (st)
					ST_ADDR: begin
						if (rise) begin
							sh <= {sh[6:0], sda_s};
							cnt <= cnt + 1'b1;
						end else if (byte_done) begin
							cnt <= 4'h0;
							rw <= sh[0];
							byte_idx <= 2'h0;
							// reads are refused while busy
							st <= addr_ack ? ST_ADDR_ACK : ST_IDLE; // RULE_03
							sda_oe_o <= addr_ack;
						end
					end
					ST_ADDR_ACK: begin
						if (fall & rw) begin
							st <= ST_TX;
							sh <= tx_byte;
							byte_idx <= FIRST_BYTE;
							sda_oe_o <= ~tx_byte[7];
							cnt <= 4'h0;
						end else if (fall) begin
							st <= ST_CMD;
							sda_oe_o <= 1'b0;
						end
					end
					ST_CMD: begin
						if (rise) begin
							sh <= {sh[6:0], sda_s};
							cnt <= cnt + 1'b1;
						end else if (byte_done) begin
							cnt <= 4'h0;
							st <= ST_CMD_ACK;
							sda_oe_o <= 1'b1;
							hold_req <= conv_ok & (sh == CMD_CONV_HOLD); // RULE_05
							if (sh == CMD_RESET) begin
								cmdrst_tgl <= ~cmdrst_tgl; // RULE_04
								conv_pend <= 1'b0;
							end else if (conv_ok) begin
								conv_tgl <= ~conv_tgl; // RULE_06 RULE_07
								conv_pend <= 1'b1;
							end
						end
					end
					ST_CMD_ACK: begin
						if (fall) begin
							sda_oe_o <= 1'b0;
							scl_oe_o <= hold_req; // RULE_05
							st <= hold_req ? ST_HOLD : ST_IDLE;
						end
					end
					ST_HOLD: begin
						// release once the core has been seen busy and idle
						if (~conv_pend & ~busy_s) begin
							scl_oe_o <= 1'b0; // RULE_05
							hold_req <= 1'b0;
							st <= ST_IDLE;
						end
					end
					ST_TX: begin
						if (fall & (cnt == LAST_BIT)) begin
							st <= ST_TX_ACK;
							sda_oe_o <= 1'b0;
						end else if (fall) begin
							sh <= {sh[6:0], 1'b0};
							sda_oe_o <= ~sh[6];
							cnt <= cnt + 1'b1;
						end
					end
					ST_TX_ACK: begin
						if (rise) begin
							mack <= ~sda_s;
						end else if (fall & more) begin
							st <= ST_TX; // RULE_17
							sh <= tx_byte;
							byte_idx <= byte_idx + 1'b1;
							sda_oe_o <= ~tx_byte[7];
							cnt <= 4'h0;
						end else if (fall) begin
							st <= ST_IDLE; // RULE_10
						end
					end
					default: begin
						st <= ST_IDLE;
					end
				endcase
			end
		end
	end

	assign sda_o = pull_low;
	assign scl_o = pull_low;
endmodule
